// ---- logic/fbp_ctrl.sv ----
// AXI4-Lite controlled host that sends protection command sequences
// to a parallel NOR flash and drives its write-protect pin level.
// Assumes one aclk domain; flash pins are joined by the bench.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Volatile command set is entered by three unlock/E0h write cycles.
// - Volatile status is read at the block address; bit 0 low = guarded.
// - Extended mode is left by a four-write exit sequence.
// - Accelerate level enters unlock bypass; raise it only in read mode.
module fbp_ctrl
	import fbp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [FBP_AW-1:0] flash_addr,
	input wire logic [15:0] flash_dq_in,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe_n,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic flash_rst_n,
	output logic [1:0] acceleration_voltage_level
);
	typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fbp_st_t;
	fbp_st_t st_q;
	logic aw_got_q, w_got_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, addr_reg_q, wdata_reg_q;
	logic [3:0] wstrb_q, op_q;
	logic [2:0] step_q;
	logic vol_mode_q, ext_mode_q, refused_q, vpb_prot_q;
	logic [15:0] rd_q;
	logic wr_fire, go, accept, refuse, cyc_done, cyc_ready, last;
	logic [15:0] cyc_rdata;
	logic [FBP_AW-1:0] ba;
	logic outer_blk;
	fbp_bus_req_t cyc_req;

	// Byte-lane merge for register writes.
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction

	// Cycles in each sequence; extended program is the short form.
	function automatic logic [2:0] seq_len(input logic [3:0] op,
		input logic ext);
		unique case (op)
			OP_READ, OP_VOL_READ: return 3'd1;
			OP_PROG: return ext ? 3'd2 : 3'd4;
			OP_ERASE: return 3'd6;
			OP_VOL_ENTER, OP_EXT_ENTER: return 3'd3;
			OP_EXT_EXIT: return 3'd4;
			default: return 3'd2;
		endcase
	endfunction

	// Address and data of one cycle of a sequence.
	function automatic fbp_bus_req_t seq_cyc(input logic [3:0] op,
		input logic [2:0] k, input logic [FBP_AW-1:0] a,
		input logic [15:0] d, input logic ext);
		fbp_bus_req_t r;
		logic [FBP_AW-1:0] a555, a2aa;
		a555 = {{(FBP_AW-12){1'b0}}, ADR_555};
		a2aa = {{(FBP_AW-12){1'b0}}, ADR_2AA};
		r = '{addr: a555, data: CMD_UNL1, wr: 1'b1};
		if (k == 3'd1 || k == 3'd4) r = '{addr: a2aa, data: CMD_UNL2, wr: 1'b1};
		unique case (op)
			OP_READ, OP_VOL_READ: r = '{addr: a, data: 16'h0000, wr: 1'b0};
			OP_PROG:
				if (ext) r = (k == 3'd0) ? '{addr: a, data: CMD_PGM, wr: 1'b1}
					: '{addr: a, data: d, wr: 1'b1};
				else if (k == 3'd2) r.data = CMD_PGM;
				else if (k == 3'd3) r = '{addr: a, data: d, wr: 1'b1};
			OP_ERASE:
				if (k == 3'd2) r.data = CMD_ERS;
				else if (k == 3'd5) r = '{addr: a, data: CMD_BLK, wr: 1'b1};
			OP_VOL_ENTER:
				if (k == 3'd2) r = '{addr: {a[FBP_AW-1:12], ADR_555},
					data: CMD_VOL, wr: 1'b1};
			OP_VOL_SET, OP_VOL_CLR:
				r = (k == 3'd0) ? '{addr: a, data: CMD_PGM, wr: 1'b1}
					: '{addr: a, data: (op == OP_VOL_SET) ? CMD_ZERO : CMD_ONE,
					wr: 1'b1};
			OP_EXT_ENTER: if (k == 3'd2) r.data = CMD_EXT;
			OP_EXT_EXIT:
				if (k == 3'd2) r.data = CMD_EXIT;
				else if (k == 3'd3) r = '{addr: a, data: CMD_ZERO, wr: 1'b1};
			OP_PROT_EXIT:
				r = '{addr: a, data: (k == 3'd0) ? CMD_EXIT : CMD_ZERO, wr: 1'b1};
			default: r = '{addr: a, data: 16'h0000, wr: 1'b0};
		endcase
		return r;
	endfunction

	// AXI write channel: address and data taken in either order.
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready = !w_got_q && !s_axi_bvalid;
	assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q > OFF_WPIN || awaddr_q[1:0] != 2'h0)
					? 2'h2 : 2'h0;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI read channel: one-cycle answer, unmapped gives SLVERR.
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			unique case (s_axi_araddr)
				OFF_CTRL: s_axi_rdata <= {28'h0, op_q};
				OFF_ADDR: s_axi_rdata <= addr_reg_q;
				OFF_WDATA: s_axi_rdata <= wdata_reg_q;
				OFF_STAT: s_axi_rdata <= {22'h0, acceleration_voltage_level,
					1'b0, rd_q[7] && rd_q[6], rd_q[7] && !rd_q[6],
					vpb_prot_q, ext_mode_q, vol_mode_q, refused_q,
					st_q != S_IDLE};
				OFF_RDATA: s_axi_rdata <= {16'h0, rd_q};
				OFF_WPIN: s_axi_rdata <= {30'h0, acceleration_voltage_level};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// A CTRL write starts an operation; the host refuses unsafe orders.
	assign go = wr_fire && awaddr_q == OFF_CTRL && wstrb_q[0];
	assign ba = addr_reg_q[FBP_AW-1:0];
	assign outer_blk = &ba[FBP_AW-1:16] || ~|ba[FBP_AW-1:16];
	always_comb begin
		refuse = st_q != S_IDLE;
		unique case (wdata_q[3:0])
			OP_VOL_SET, OP_VOL_CLR, OP_VOL_READ:
				refuse = refuse || !vol_mode_q;
			OP_ERASE:
				refuse = refuse || vol_mode_q || ext_mode_q
					|| (acceleration_voltage_level == WP_LOW && outer_blk);
			OP_PROG:
				refuse = refuse || vol_mode_q || (ext_mode_q
					? ba < OTP_UPPER
					: acceleration_voltage_level == WP_LOW && outer_blk);
			OP_READ, OP_VOL_ENTER, OP_EXT_ENTER: refuse = refuse || vol_mode_q;
			OP_EXT_EXIT: refuse = refuse || !ext_mode_q;
			OP_PROT_EXIT: refuse = refuse;
			default: refuse = 1'b1;
		endcase
	end
	assign accept = go && !refuse;

	// Software registers and the pin level; acceleration only from read.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_reg_q <= 32'h0;
			wdata_reg_q <= 32'h0;
			op_q <= OP_READ;
			acceleration_voltage_level <= WP_HIGH;
			refused_q <= 1'b0;
		end else begin
			if (wr_fire && awaddr_q == OFF_ADDR)
				addr_reg_q <= merge(addr_reg_q, wdata_q, wstrb_q);
			if (wr_fire && awaddr_q == OFF_WDATA)
				wdata_reg_q <= merge(wdata_reg_q, wdata_q, wstrb_q);
			if (accept) op_q <= wdata_q[3:0];
			if (go) refused_q <= refuse;
			if (wr_fire && awaddr_q == OFF_WPIN && wstrb_q[0]) begin
				if (wdata_q[1:0] == WP_LOW || wdata_q[1:0] == WP_HIGH)
					acceleration_voltage_level <= wdata_q[1:0];
				else if (wdata_q[1:0] == WP_ACCEL && st_q == S_IDLE
					&& !vol_mode_q && !ext_mode_q)
					acceleration_voltage_level <= WP_ACCEL;
				else
					refused_q <= 1'b1;
			end
		end
	end

	// Sequencer: one bus cycle at a time through the cycle engine.
	assign last = step_q == seq_len(op_q, ext_mode_q) - 3'd1;
	assign cyc_req = seq_cyc(op_q, step_q, ba, wdata_reg_q[15:0], ext_mode_q);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= S_IDLE;
			step_q <= 3'd0;
		end else begin
			unique case (st_q)
				S_IDLE: if (accept) begin
					st_q <= S_ISSUE;
					step_q <= 3'd0;
				end
				S_ISSUE: if (cyc_ready) st_q <= S_WAIT;
				S_WAIT: if (cyc_done) begin
					st_q <= last ? S_IDLE : S_ISSUE;
					step_q <= last ? 3'd0 : step_q + 3'd1;
				end
			endcase
		end
	end

	// Mode tracking: each exit sequence clears only its own mode flag; reset returns both to read mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vol_mode_q <= 1'b0;
			ext_mode_q <= 1'b0;
			vpb_prot_q <= 1'b0;
			rd_q <= 16'h0000;
			flash_rst_n <= 1'b0;
		end else begin
			flash_rst_n <= 1'b1;
			if (st_q == S_WAIT && cyc_done && last) begin
				if (op_q == OP_VOL_ENTER) vol_mode_q <= 1'b1;
				if (op_q == OP_PROT_EXIT) vol_mode_q <= 1'b0;
				if (op_q == OP_EXT_ENTER) ext_mode_q <= 1'b1;
				if (op_q == OP_EXT_EXIT) ext_mode_q <= 1'b0;
				if (op_q == OP_VOL_READ) vpb_prot_q <= !cyc_rdata[0];
				if (op_q == OP_READ || op_q == OP_VOL_READ) rd_q <= cyc_rdata;
			end
		end
	end

	fbp_cycle u_cyc (
		.aclk(aclk),
		.aresetn(aresetn),
		.req_valid(st_q == S_ISSUE),
		.req(cyc_req),
		.req_ready(cyc_ready),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.flash_addr(flash_addr),
		.dq_in(flash_dq_in),
		.dq_out(flash_dq_out),
		.dq_oe_n(flash_dq_oe_n),
		.ce_n(flash_ce_n),
		.we_n(flash_we_n),
		.oe_n(flash_oe_n)
	);

	a_vol_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		go && !vol_mode_q && wdata_q[3:0] == OP_VOL_SET |=> refused_q
		&& (st_q == S_IDLE || $past(st_q) != S_IDLE))
		else $error("volatile op outside set taken");
	a_ext_erase: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q != S_IDLE && ext_mode_q |-> op_q != OP_ERASE)
		else $error("erase running in extended mode");
	a_accel_read: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(acceleration_voltage_level == WP_ACCEL) |-> $past(st_q) ==
		S_IDLE && !ext_mode_q && !vol_mode_q) else $error("bad accel entry");
	a_wp_outer: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q != S_IDLE && op_q == OP_ERASE |-> !(outer_blk &&
		acceleration_voltage_level == WP_LOW)) else $error("outer erase");
	a_otp_lower: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q != S_IDLE && op_q == OP_PROG && ext_mode_q |-> ba >= OTP_UPPER)
		else $error("program to factory half");
	a_vol_enter: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == S_WAIT && cyc_done && last && op_q == OP_VOL_ENTER
		|=> vol_mode_q && st_q == S_IDLE) else $error("volatile entry lost");
	a_exit_prot: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(vol_mode_q) |-> $past(op_q) == OP_PROT_EXIT)
		else $error("volatile set left without exit");
	a_reset_read: assert property (@(posedge aclk)
		!aresetn |=> !ext_mode_q && !vol_mode_q) else $error("reset mode");
	a_vol_ack: assert property (@(posedge aclk) disable iff (!aresetn)
		accept && wdata_q[3:0] == OP_VOL_SET |=> st_q == S_ISSUE ##1
		!flash_ce_n [*2]) else $error("volatile set not issued");
	c_vol_set: cover property (@(posedge aclk) disable iff (!aresetn)
		st_q == S_WAIT && cyc_done && last && op_q == OP_VOL_SET);
	c_ext_exit: cover property (@(posedge aclk) disable iff (!aresetn)
		$fell(ext_mode_q));
	c_refused: cover property (@(posedge aclk) disable iff (!aresetn)
		go && refuse);
endmodule : fbp_ctrl

// ---- inc/fbp_pkg.sv ----
// Shared constants and carriers of the flash block-protection controller.
// Assumes a 40 MHz aclk and a x16 asynchronous NOR flash on the pins.
package fbp_pkg;
	localparam int FBP_AW = 24; // Word address width of the flash.
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0C;
	localparam logic [7:0] OFF_RDATA = 8'h10;
	localparam logic [7:0] OFF_WPIN = 8'h14;
	// Operation codes written to CTRL[3:0].
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_PROG = 4'h1;
	localparam logic [3:0] OP_ERASE = 4'h2;
	localparam logic [3:0] OP_VOL_ENTER = 4'h3;
	localparam logic [3:0] OP_VOL_SET = 4'h4;
	localparam logic [3:0] OP_VOL_CLR = 4'h5;
	localparam logic [3:0] OP_VOL_READ = 4'h6;
	localparam logic [3:0] OP_EXT_ENTER = 4'h7;
	localparam logic [3:0] OP_EXT_EXIT = 4'h8;
	localparam logic [3:0] OP_PROT_EXIT = 4'h9;
	// Status bit positions.
	localparam int ST_BUSY = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_VOL = 2;
	localparam int ST_EXT = 3;
	localparam int ST_VPB_PROT = 4;
	localparam int ST_OTP_OPEN = 5;
	localparam int ST_OTP_LOCKED = 6;
	localparam int ST_WP_LSB = 8;
	// Write-protect pin levels.
	localparam logic [1:0] WP_LOW = 2'h0;
	localparam logic [1:0] WP_HIGH = 2'h1;
	localparam logic [1:0] WP_ACCEL = 2'h2;
	// Flash command bytes and unlock addresses.
	localparam logic [15:0] CMD_UNL1 = 16'h00AA;
	localparam logic [15:0] CMD_UNL2 = 16'h0055;
	localparam logic [15:0] CMD_VOL = 16'h00E0;
	localparam logic [15:0] CMD_PGM = 16'h00A0;
	localparam logic [15:0] CMD_ERS = 16'h0080;
	localparam logic [15:0] CMD_BLK = 16'h0030;
	localparam logic [15:0] CMD_EXT = 16'h0088;
	localparam logic [15:0] CMD_EXIT = 16'h0090;
	localparam logic [15:0] CMD_ZERO = 16'h0000;
	localparam logic [15:0] CMD_ONE = 16'h0001;
	localparam logic [11:0] ADR_555 = 12'h555;
	localparam logic [11:0] ADR_2AA = 12'h2AA;
	localparam logic [FBP_AW-1:0] OTP_UPPER = 24'h000080;
	// Bus-cycle timing at 40 MHz; least times round up.
	localparam int CLK_KHZ = 40000;
	localparam int T_WE_NS = 35;
	localparam int T_ACC_NS = 70;
	localparam int T_REC_NS = 30;
	localparam int SYNC_CYC = 2;
	localparam int WE_CYC = (T_WE_NS * CLK_KHZ + 999999) / 1000000;
	localparam int ACC_CYC = (T_ACC_NS * CLK_KHZ + 999999) / 1000000;
	localparam int RD_CYC = ACC_CYC + SYNC_CYC;
	localparam int REC_CYC = (T_REC_NS * CLK_KHZ + 999999) / 1000000;
	typedef struct packed {
		logic [FBP_AW-1:0] addr;
		logic [15:0] data;
		logic wr;
	} fbp_bus_req_t;
endpackage : fbp_pkg

// ---- logic/fbp_cycle.sv ----
// One asynchronous flash bus cycle: address setup, strobe, recovery.
// Assumes dq_in comes straight from the pin, so it is synchronised here.
`timescale 1ns/1ps
module fbp_cycle
	import fbp_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic req_valid,
	input fbp_bus_req_t req,
	output logic req_ready,
	output logic done,
	output logic [15:0] rdata,
	output logic [FBP_AW-1:0] flash_addr,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe_n,
	output logic ce_n,
	output logic we_n,
	output logic oe_n
);
	typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fbp_cyc_st_t;
	fbp_cyc_st_t st_q, st_d;
	fbp_bus_req_t req_q;
	logic [3:0] cnt_q;
	logic [15:0] dq_meta_q, dq_sync_q;
	logic wr_now;

	// Two-stage synchroniser on the data pins.
	always_ff @(posedge aclk) begin
		dq_meta_q <= dq_in;
		dq_sync_q <= dq_meta_q;
	end

	// Next state; the strobe lasts long enough to cover access plus sync.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			E_IDLE: if (req_valid) st_d = E_SETUP;
			E_SETUP: st_d = E_STROBE;
			E_STROBE: if (cnt_q == 4'h0) st_d = E_HOLD;
			E_HOLD: if (cnt_q == 4'h0) st_d = E_IDLE;
		endcase
	end
	assign req_ready = (st_q == E_IDLE);
	assign wr_now = (st_q == E_IDLE) ? req.wr : req_q.wr;

	// Sequence state and phase counter.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= E_IDLE;
			cnt_q <= 4'h0;
			req_q <= '0;
		end else begin
			st_q <= st_d;
			if (st_q == E_IDLE && req_valid)
				req_q <= req;
			if (st_q == E_SETUP)
				cnt_q <= req_q.wr ? 4'(WE_CYC - 1) : 4'(RD_CYC - 1);
			else if (st_q == E_STROBE && cnt_q == 4'h0)
				cnt_q <= 4'(REC_CYC - 1);
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
		end
	end

	// Pins come from flops; data is driven only during a write cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			dq_oe_n <= 1'b1;
			flash_addr <= '0;
			dq_out <= 16'h0000;
		end else begin
			ce_n <= (st_d == E_IDLE);
			we_n <= !(st_d == E_STROBE && wr_now);
			oe_n <= !(st_d == E_STROBE && !wr_now);
			dq_oe_n <= !(st_d != E_IDLE && wr_now);
			if (st_q == E_IDLE && req_valid) begin
				flash_addr <= req.addr;
				dq_out <= req.data;
			end
		end
	end

	// Read data is taken at the last strobe cycle, done marks the end.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= 16'h0000;
			done <= 1'b0;
		end else begin
			done <= (st_q == E_HOLD && cnt_q == 4'h0);
			if (st_q == E_STROBE && cnt_q == 4'h0 && !req_q.wr)
				rdata <= dq_sync_q;
		end
	end

	a_strobe_excl: assert property (@(posedge aclk) disable iff (!aresetn)
		!(!we_n && !oe_n)) else $error("write and read strobes overlap");
	a_we_width: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(we_n) |-> !we_n [*2] ##1 we_n)
		else $error("write strobe width wrong");
	a_drive_on_we: assert property (@(posedge aclk) disable iff (!aresetn)
		!we_n |-> !dq_oe_n && !ce_n) else $error("write without data drive");
endmodule : fbp_cycle

// ---- testbench/fbp_flash_model.sv ----
// Behavioural x16 NOR flash: protection bits, extra block, pin guard.
// Assumes the host keeps dq released while it reads.
`timescale 1ns/1ps
module fbp_flash_model
	import fbp_pkg::*;
#(
	parameter int GUARD_BLK = 5,
	parameter logic VPB_BOOT = 1'b1
)
(
	input wire logic [FBP_AW-1:0] addr,
	input wire logic [15:0] din,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic rst_n,
	input wire logic [1:0] level,
	output logic [15:0] dout
);
	logic [15:0] mem [int];
	logic [15:0] otp [int];
	logic [511:0] volatile_block_guard_bit;
	logic [7:0] h0, h1;
	logic vol, ext, hit;
	logic [15:0] last = 16'h0;
	int b;
	// Commands are decoded at the end of each write strobe.
	always @(posedge we_n or negedge rst_n) begin
		if (!rst_n) begin
			vol = 1'b0;
			ext = 1'b0;
			volatile_block_guard_bit = {512{VPB_BOOT}};
			h0 = 8'hFF;
			h1 = 8'hFF;
		end else if (!ce_n) begin
			b = int'(addr[23:15]);
			hit = 1'b1;
			if (h0 == 8'h90 && din[7:0] == 8'h00) begin
				vol = 1'b0;
				ext = 1'b0;
			end else if (vol && h0 == 8'hA0 && din[15:1] == 15'h0)
				volatile_block_guard_bit[b] = din[0];
			else if (h1 == 8'hAA && h0 == 8'h55 && din[7:0] == 8'hE0)
				vol = 1'b1;
			else if (h1 == 8'hAA && h0 == 8'h55 && din[7:0] == 8'h88)
				ext = 1'b1;
			else if (ext && h0 == 8'hA0) begin
				if (addr[7])
					otp[addr[7:0]] = din;
			end else if (!vol && h0 == 8'hA0 && h1 == 8'h55) begin
				// Outer blocks are 0, 1, 510 and 511.
				if (b != GUARD_BLK && volatile_block_guard_bit[b] && (level != WP_LOW ||
					(b > 1 && b < 510)))
					mem[addr] = din;
			end else
				hit = 1'b0;
			h1 = hit ? 8'hFF : h0;
			h0 = hit ? 8'hFF : din[7:0];
		end
	end
	// A released bus shows the inverse of the last word, not a stale copy.
	always @(oe_n or ce_n) begin
		if (!oe_n && !ce_n) begin
			#20;
			if (vol)
				dout = {15'h0, volatile_block_guard_bit[addr[23:15]]};
			else if (ext)
				dout = otp.exists(addr[7:0]) ? otp[addr[7:0]] : 16'hFFFF;
			else
				dout = mem.exists(addr) ? mem[addr] : 16'hFFFF;
			last = dout;
		end else
			dout = ~last;
	end
endmodule : fbp_flash_model

// ---- testbench/tb.sv ----
// Self-checking bench: AXI4-Lite tasks drive the controller at a flash.
// Assumes the flash model above sits on the flash pins.
`timescale 1ns/1ps
module tb;
	import fbp_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rdat;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp, lvl;
	logic [FBP_AW-1:0] fa;
	logic [15:0] dq_m, dq_h, dq_w;
	logic dq_oe_n, ce_n, we_n, oe_n, rst_n;
	int failures = 0, checked = 0;
	// The shared data wire follows whoever drives it.
	assign dq_w = dq_oe_n ? dq_m : dq_h;
	always #12.5 aclk = ~aclk;
	fbp_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .flash_addr(fa), .flash_dq_in(dq_w),
		.flash_dq_out(dq_h), .flash_dq_oe_n(dq_oe_n), .flash_ce_n(ce_n),
		.flash_we_n(we_n), .flash_oe_n(oe_n), .flash_rst_n(rst_n),
		.acceleration_voltage_level(lvl));
	fbp_flash_model flash (.addr(fa), .din(dq_w), .ce_n(ce_n),
		.we_n(we_n), .oe_n(oe_n), .rst_n(rst_n), .level(lvl),
		.dout(dq_m));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic tmo();
		failures++;
		$display("[ERR] %0t wait ran out", $time);
		conclude();
	endtask : tmo
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Ready is sampled mid-cycle; the transfer lands on the next edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ha, hw, hb;
		// One edge passes first, so bready never falls and rises in one step.
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hb = 1'b0;
		for (n = 0; n < 50 && !hb; n++) begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ha)
				awvalid <= 1'b0;
			if (hw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!hb)
			tmo();
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		logic ha, hr;
		// One edge passes first, so rready never falls and rises in one step.
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hr = 1'b0;
		for (n = 0; n < 50 && !hr; n++) begin
			@(negedge aclk);
			ha = arvalid && arready;
			hr = rvalid;
			rdat = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ha)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!hr)
			tmo();
	endtask : rd
	// Starts one operation and leaves the final status word in rdat.
	task automatic op(input logic [3:0] c, input logic [23:0] a,
		input logic [15:0] d);
		int n;
		wr(OFF_ADDR, {8'h00, a});
		wr(OFF_WDATA, {16'h0, d});
		wr(OFF_CTRL, {28'h0, c});
		for (n = 0; n < 100; n++) begin
			rd(OFF_STAT);
			if (rdat[ST_BUSY] === 1'b0)
				break;
		end
		if (n == 100)
			tmo();
	endtask : op
	task automatic rdback(input logic [23:0] a, input logic [15:0] e);
		op(OP_READ, a, 16'h0);
		rd(OFF_RDATA);
		chk(rdat[15:0], e);
	endtask : rdback
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFF_STAT);
		chk(rdat[9:2], 8'h40);
		rd(8'h20);
		chk(resp, 2'h2);
		wr(8'h18, 32'h0);
		chk(resp, 2'h2);
		wr(OFF_ADDR, 32'h0);
		chk(resp, 2'h0);
		op(OP_VOL_SET, 24'h010000, 16'h0);
		chk(rdat[ST_REFUSED], 1);
		$display("test reset done");
		op(OP_VOL_ENTER, 24'h010000, 16'h0);
		chk(rdat[ST_VOL], 1);
		op(OP_VOL_SET, 24'h010000, 16'h0);
		op(OP_VOL_SET, 24'h018000, 16'h0);
		op(OP_VOL_READ, 24'h010000, 16'h0);
		chk(rdat[ST_VPB_PROT], 1);
		op(OP_VOL_CLR, 24'h010000, 16'h0);
		op(OP_VOL_READ, 24'h010000, 16'h0);
		chk(rdat[ST_VPB_PROT], 0);
		op(OP_VOL_READ, 24'h018000, 16'h0);
		chk(rdat[ST_VPB_PROT], 1);
		op(OP_PROT_EXIT, 24'h0, 16'h0);
		chk(rdat[ST_VOL], 0);
		op(OP_PROG, 24'h018004, 16'h1111);
		rdback(24'h018004, 16'hFFFF);
		op(OP_PROG, 24'h028000, 16'h2222);
		rdback(24'h028000, 16'hFFFF);
		$display("test volatile done");
		wr(OFF_WPIN, {30'h0, WP_LOW});
		op(OP_PROG, 24'h000010, 16'h1234);
		chk(rdat[ST_REFUSED], 1);
		op(OP_PROG, 24'hFFFF00, 16'h1234);
		chk(rdat[ST_REFUSED], 1);
		chk(lvl, WP_LOW);
		op(OP_ERASE, 24'h000000, 16'h0);
		chk(rdat[ST_REFUSED], 1);
		wr(OFF_WPIN, {30'h0, WP_HIGH});
		op(OP_PROG, 24'h000010, 16'h1234);
		rdback(24'h000010, 16'h1234);
		op(OP_ERASE, 24'h100000, 16'h0);
		chk(rdat[ST_REFUSED], 0);
		$display("test pin done");
		op(OP_EXT_ENTER, 24'h0, 16'h0);
		chk(rdat[ST_EXT], 1);
		op(OP_ERASE, 24'h0, 16'h0);
		chk(rdat[ST_REFUSED], 1);
		op(OP_PROG, 24'h000010, 16'h0BAD);
		chk(rdat[ST_REFUSED], 1);
		op(OP_PROG, OTP_UPPER, 16'h5A5A);
		rdback(OTP_UPPER, 16'h5A5A);
		rdback(24'h000010, 16'hFFFF);
		rd(OFF_STAT);
		chk(rdat[ST_OTP_LOCKED:ST_OTP_OPEN], 2'h2);
		op(OP_PROG, 24'h000081, 16'h0080);
		rdback(24'h000081, 16'h0080);
		rd(OFF_STAT);
		chk(rdat[ST_OTP_LOCKED:ST_OTP_OPEN], 2'h1);
		wr(OFF_WPIN, {30'h0, WP_ACCEL});
		rd(OFF_STAT);
		chk(rdat[9:8], WP_HIGH);
		op(OP_EXT_EXIT, 24'h0, 16'h0);
		chk(rdat[ST_EXT], 0);
		rdback(OTP_UPPER, 16'hFFFF);
		rdback(24'h000010, 16'h1234);
		op(OP_EXT_EXIT, 24'h0, 16'h0);
		chk(rdat[ST_REFUSED], 1);
		wr(OFF_WPIN, {30'h0, WP_ACCEL});
		chk(lvl, WP_ACCEL);
		wr(OFF_WPIN, 32'h3);
		chk(lvl, WP_ACCEL);
		$display("test extended done");
		conclude();
	end
endmodule : tb
